/* File: pcp_map.svh */
// Purpose: offsets, counts and codes of the peripheral configuration port
// Assumes: included by the link and top files of the block
// Notes:   definitions only
`ifndef PCP_MAP_SVH
`define PCP_MAP_SVH

// ----------------------------------------------------------------------------
// byte and link timing
// ----------------------------------------------------------------------------
`define PCP_BYTE_W       8
`define PCP_CNT_W        3
`define PCP_FIRST_EDGE   3'h2
`define PCP_BYTE_EDGES   3'h0
`define PCP_LAST_BIT     4'h7

// ----------------------------------------------------------------------------
// start-up release orders (gsr, io, done)
// ----------------------------------------------------------------------------
`define PCP_ORD_GSR_IO_DONE  2'h0
`define PCP_ORD_DONE_IO_GSR  2'h1
`define PCP_ORD_IO_GSR_DONE  2'h2
`define PCP_ORD_ALL_AT_ONCE  2'h3
`define PCP_CFG_BYTES        16

`endif

/* File: pcp_pkg.sv */
// Purpose: types of the peripheral configuration port
// Assumes: pcp_map.svh holds the numbers
// Notes:   no constants here

package pcp_pkg;

    // ------------------------------------------------------------------------
    // pins of the byte port
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic       chip_select_low_true_n;
        logic       chip_select_high_true;
        logic       wr_n;
        logic       rd_n;
        logic       reset_pin;
        logic       init_pin;
        logic       sync_mode;
        logic [7:0] data;
    } pcp_pins_t;

    typedef enum logic [4:0] {
        PCP_IDLE    = 5'h01,
        PCP_LOAD    = 5'h02,
        PCP_STARTUP = 5'h04,
        PCP_DONE    = 5'h08,
        PCP_ABORT   = 5'h10
    } pcp_state_t;

    // ------------------------------------------------------------------------
    // startup release outputs
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic global_set_reset_n;
        logic user_io_enable;
        logic done;
    } pcp_release_t;

endpackage : pcp_pkg

/* File: pcp_link.sv */
// Purpose: config_clock side of the synchronous byte port
// Assumes: config_clock may stop outside a load; init_pin is asynchronous
// Notes:   serial output changes on falling edges of config_clock
`timescale 1ns/1ps
`include "pcp_map.svh"

module pcp_link (
    input  wire logic                   config_clock,
    input  wire logic                   init_pin,
    input  wire logic [`PCP_BYTE_W-1:0] data_pin,
    output logic      [`PCP_BYTE_W-1:0] byte_out,
    output logic                        byte_toggle,
    output logic                        ack,
    output logic                        dout
);

    typedef struct packed {
        logic                   init_s1;
        logic                   init_s2;
        logic                   started;
        logic [`PCP_CNT_W-1:0]  cnt;
        logic [`PCP_BYTE_W-1:0] byte_v;
        logic                   tog;
        logic                   ack;
    } pcp_link_st_t;

    pcp_link_st_t           st_ff;
    pcp_link_st_t           nxt_st;
    logic [`PCP_BYTE_W-1:0] ser_ff;
    logic                   cap;

    // ------------------------------------------------------------------------
    // capture on the second edge after init, then every eighth
    // ------------------------------------------------------------------------
    always_comb begin
        nxt_st         = st_ff;
        nxt_st.init_s1 = init_pin;
        nxt_st.init_s2 = st_ff.init_s1;
        cap            = st_ff.init_s2 &&
                         (st_ff.started ? (st_ff.cnt + 3'h1 == `PCP_BYTE_EDGES)
                                        : (st_ff.cnt + 3'h1 == `PCP_FIRST_EDGE));
        nxt_st.ack     = cap;
        if (!st_ff.init_s2) begin
            nxt_st.started = 1'b0;
            nxt_st.cnt     = '0;
        end else if (cap) begin
            nxt_st.started = 1'b1;
            nxt_st.cnt     = '0;
            nxt_st.byte_v  = data_pin;
            nxt_st.tog     = ~st_ff.tog;
        end else begin
            nxt_st.cnt     = st_ff.cnt + 3'h1;
        end
    end

    always_ff @(posedge config_clock) begin
        st_ff <= nxt_st;
    end

    // ------------------------------------------------------------------------
    // daisy-chain serialiser, loads half a cycle after the acknowledge rises
    // ------------------------------------------------------------------------
    always_ff @(negedge config_clock) begin
        if (!st_ff.init_s2) begin
            ser_ff <= '0;
        end else if (st_ff.ack) begin
            ser_ff <= st_ff.byte_v;
        end else begin
            ser_ff <= {ser_ff[`PCP_BYTE_W-2:0], 1'b0};
        end
    end

    assign byte_out    = st_ff.byte_v;
    assign byte_toggle = st_ff.tog;
    assign ack         = st_ff.ack;
    assign dout        = ser_ff[`PCP_BYTE_W-1];

    property p_first_byte;
        @(posedge config_clock) $rose(st_ff.init_s2) |-> ##1 cap;
    endproperty
    a_first_byte: assert property (p_first_byte) else $error("first byte not on second edge");

    property p_byte_spacing;
        @(posedge config_clock) disable iff (!st_ff.init_s2)
            cap |=> (!cap)[*7] ##1 cap;
    endproperty
    a_byte_spacing: assert property (p_byte_spacing) else $error("bytes not eight edges apart");

    sequence s_ack_pulse;
        ack ##1 !ack;
    endsequence
    property p_ack;
        @(posedge config_clock) cap |=> s_ack_pulse;
    endproperty
    a_ack: assert property (p_ack) else $error("acknowledge not a one-cycle pulse after capture");

endmodule : pcp_link

/* File: pcp_top.sv */
// Purpose: byte-wide peripheral configuration port with serial loader
// Assumes: pins are asynchronous to clock; config_clock is the link clock
// Notes:   cfg_bit/cfg_bit_valid feed configuration memory, dout feeds the chain
`timescale 1ns/1ps
`include "pcp_map.svh"

module pcp_top #(
    parameter int CFG_BYTES = `PCP_CFG_BYTES
) (
    input  wire logic                   clock,
    input  wire logic                   sys_rst,
    input  wire logic                   config_clock,
    input  wire logic                   chip_select_low_true_n,
    input  wire logic                   chip_select_high_true,
    input  wire logic                   wr_n,
    input  wire logic                   rd_n,
    input  wire logic                   reset_pin,
    input  wire logic                   init_pin,
    input  wire logic                   sync_mode,
    input  wire logic [`PCP_BYTE_W-1:0] data_in,
    input  wire logic [1:0]             startup_order,
    output logic                        status_bit_pin_out,
    output logic                        status_bit_pin_oe,
    output logic                        ready,
    output logic                        dout,
    output logic                        cfg_bit,
    output logic                        cfg_bit_valid,
    output logic                        global_set_reset_n,
    output logic                        user_io_enable,
    output logic                        done
);

    typedef struct packed {
        pcp_pkg::pcp_pins_t     pin_s1;
        pcp_pkg::pcp_pins_t     pin_s2;
        logic                   tog_s1;
        logic                   tog_s2;
        logic                   tog_s3;
        logic                   wr_prev;
        pcp_pkg::pcp_state_t    state;
        logic [`PCP_BYTE_W-1:0] hold;
        logic                   hold_full;
        logic [`PCP_BYTE_W-1:0] shf;
        logic [3:0]             shf_cnt;
        logic                   shf_busy;
        logic                   cfg_bit;
        logic                   cfg_valid;
        logic                   dout;
        logic [15:0]            byte_cnt;
        logic [1:0]             step;
        pcp_pkg::pcp_release_t  rel;
    } pcp_st_t;

    pcp_st_t                st_ff;
    pcp_st_t                nxt_st;
    logic [`PCP_BYTE_W-1:0] link_byte;
    logic                   link_toggle;
    logic                   link_ack;
    logic                   link_dout;
    logic                   selected;
    logic                   async_mode;
    logic                   wr_rise;
    logic                   link_new;
    logic                   take;
    logic                   xfer;
    logic                   async_ready;
    logic [1:0]             gsr_step;
    logic [1:0]             io_step;
    logic [1:0]             done_step;

    // ------------------------------------------------------------------------
    // link clock domain
    // ------------------------------------------------------------------------
    pcp_link u_link (
        .config_clock (config_clock),
        .init_pin     (init_pin),
        .data_pin     (data_in),
        .byte_out     (link_byte),
        .byte_toggle  (link_toggle),
        .ack          (link_ack),
        .dout         (link_dout)
    );

    // ------------------------------------------------------------------------
    // decode of the synchronised pins
    // ------------------------------------------------------------------------
    assign async_mode  = !st_ff.pin_s2.sync_mode;
    assign selected    = !st_ff.pin_s2.chip_select_low_true_n &&
                         st_ff.pin_s2.chip_select_high_true;
    assign wr_rise     = st_ff.pin_s2.wr_n && !st_ff.wr_prev;
    assign async_ready = !st_ff.hold_full;
    assign link_new    = st_ff.tog_s2 ^ st_ff.tog_s3;
    assign take        = (st_ff.state == pcp_pkg::PCP_LOAD) && async_ready &&
                         (async_mode ? (wr_rise && selected) : link_new);
    assign xfer        = st_ff.hold_full && !st_ff.shf_busy;

    // ------------------------------------------------------------------------
    // start-up release order
    // ------------------------------------------------------------------------
    always_comb begin
        case (startup_order)
            `PCP_ORD_GSR_IO_DONE: begin
                gsr_step  = 2'h0;
                io_step   = 2'h1;
                done_step = 2'h2;
            end
            `PCP_ORD_DONE_IO_GSR: begin
                gsr_step  = 2'h2;
                io_step   = 2'h1;
                done_step = 2'h0;
            end
            `PCP_ORD_IO_GSR_DONE: begin
                gsr_step  = 2'h1;
                io_step   = 2'h0;
                done_step = 2'h2;
            end
            default: begin
                gsr_step  = 2'h0;
                io_step   = 2'h0;
                done_step = 2'h0;
            end
        endcase
    end

    // ------------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------------
    always_comb begin
        nxt_st                         = st_ff;
        nxt_st.pin_s1.chip_select_low_true_n = chip_select_low_true_n;
        nxt_st.pin_s1.chip_select_high_true  = chip_select_high_true;
        nxt_st.pin_s1.wr_n             = wr_n;
        nxt_st.pin_s1.rd_n             = rd_n;
        nxt_st.pin_s1.reset_pin        = reset_pin;
        nxt_st.pin_s1.init_pin         = init_pin;
        nxt_st.pin_s1.sync_mode        = sync_mode;
        nxt_st.pin_s1.data             = data_in;
        nxt_st.pin_s2                  = st_ff.pin_s1;
        nxt_st.tog_s1                  = link_toggle;
        nxt_st.tog_s2                  = st_ff.tog_s1;
        nxt_st.tog_s3                  = st_ff.tog_s2;
        nxt_st.wr_prev                 = st_ff.pin_s2.wr_n;
        nxt_st.cfg_valid               = 1'b0;

        // hold register, written by either port
        if (take) begin
            nxt_st.hold      = async_mode ? st_ff.pin_s2.data : link_byte;
            nxt_st.hold_full = 1'b1;
        end else if (xfer) begin
            nxt_st.hold_full = 1'b0;
        end

        // shift register, one bit a cycle into configuration memory
        if (xfer) begin
            nxt_st.shf      = st_ff.hold;
            nxt_st.shf_cnt  = '0;
            nxt_st.shf_busy = 1'b1;
            nxt_st.byte_cnt = st_ff.byte_cnt + 16'h1;
        end else if (st_ff.shf_busy) begin
            nxt_st.cfg_bit   = st_ff.shf[`PCP_BYTE_W-1];
            nxt_st.cfg_valid = 1'b1;
            nxt_st.dout      = st_ff.shf[`PCP_BYTE_W-1];
            nxt_st.shf       = {st_ff.shf[`PCP_BYTE_W-2:0], 1'b0};
            nxt_st.shf_cnt   = st_ff.shf_cnt + 4'h1;
            nxt_st.shf_busy  = (st_ff.shf_cnt != `PCP_LAST_BIT);
        end

        case (st_ff.state)
            pcp_pkg::PCP_IDLE: begin
                nxt_st.rel.global_set_reset_n = 1'b0;
                nxt_st.byte_cnt               = '0;
                if (st_ff.pin_s2.init_pin && !st_ff.pin_s2.reset_pin) begin
                    nxt_st.state = pcp_pkg::PCP_LOAD;
                end
            end
            pcp_pkg::PCP_LOAD: begin
                nxt_st.rel.global_set_reset_n = 1'b0;
                if (st_ff.pin_s2.reset_pin) begin
                    nxt_st.state = pcp_pkg::PCP_ABORT;
                end else if (st_ff.byte_cnt == 16'(CFG_BYTES) && !st_ff.hold_full &&
                             !st_ff.shf_busy) begin
                    nxt_st.state = pcp_pkg::PCP_STARTUP;
                    nxt_st.step  = '0;
                end
            end
            pcp_pkg::PCP_STARTUP: begin
                if (st_ff.step == gsr_step) begin
                    nxt_st.rel.global_set_reset_n = 1'b1;
                end
                if (st_ff.step == io_step) begin
                    nxt_st.rel.user_io_enable = 1'b1;
                end
                if (st_ff.step == done_step) begin
                    nxt_st.rel.done = 1'b1;
                end
                nxt_st.step = st_ff.step + 2'h1;
                if (st_ff.step == 2'h2) begin
                    nxt_st.state = pcp_pkg::PCP_DONE;
                end
            end
            pcp_pkg::PCP_DONE: begin
                if (!st_ff.pin_s2.init_pin) begin
                    nxt_st.state = pcp_pkg::PCP_IDLE;
                    nxt_st.rel   = '0;
                end
            end
            pcp_pkg::PCP_ABORT: begin
                nxt_st.rel.global_set_reset_n = 1'b0;
                nxt_st.hold_full              = 1'b0;
                nxt_st.shf_busy               = 1'b0;
                nxt_st.cfg_valid              = 1'b0;
                if (!st_ff.pin_s2.init_pin && !st_ff.pin_s2.reset_pin) begin
                    nxt_st.state = pcp_pkg::PCP_IDLE;
                end
            end
            default: begin
                nxt_st.state = pcp_pkg::PCP_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            st_ff       <= '0;
            st_ff.state <= pcp_pkg::PCP_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------------
    assign ready              = async_mode ? async_ready : link_ack;
    assign status_bit_pin_oe  = async_mode && selected && st_ff.pin_s2.wr_n &&
                                !st_ff.pin_s2.rd_n;
    assign status_bit_pin_out = async_ready;
    assign dout               = async_mode ? st_ff.dout : link_dout;
    assign cfg_bit            = st_ff.cfg_bit;
    assign cfg_bit_valid      = st_ff.cfg_valid;
    assign global_set_reset_n = st_ff.rel.global_set_reset_n;
    assign user_io_enable     = st_ff.rel.user_io_enable;
    assign done               = st_ff.rel.done;

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    property p_ready_low;
        async_mode && st_ff.hold_full |-> !ready;
    endproperty
    a_ready_low: assert property (p_ready_low) else $error("ready high with hold full");

    property p_latch;
        take |=> st_ff.hold_full;
    endproperty
    a_latch: assert property (p_latch) else $error("write not latched into hold");

    property p_fast_xfer;
        st_ff.hold_full && !st_ff.shf_busy && !st_ff.pin_s2.reset_pin |=> st_ff.shf_busy && !st_ff.hold_full;
    endproperty
    a_fast_xfer: assert property (p_fast_xfer) else $error("empty shifter did not take byte");

    property p_slow_xfer;
        st_ff.hold_full && st_ff.shf_busy && st_ff.state == pcp_pkg::PCP_LOAD &&
        !st_ff.pin_s2.reset_pin |=> st_ff.hold_full;
    endproperty
    a_slow_xfer: assert property (p_slow_xfer) else $error("hold freed while shifter busy");

    sequence s_eight_bits;
        cfg_bit_valid[*8];
    endsequence
    property p_eight_bits;
        xfer && st_ff.state == pcp_pkg::PCP_LOAD && !st_ff.pin_s2.reset_pin |=> ##1 s_eight_bits;
    endproperty
    a_eight_bits: assert property (p_eight_bits) else $error("byte not shifted over eight cycles");

    property p_status_pin;
        status_bit_pin_oe |-> status_bit_pin_out == ready && !st_ff.pin_s2.rd_n;
    endproperty
    a_status_pin: assert property (p_status_pin) else $error("status pin not showing ready");

    property p_gsr_held;
        st_ff.state == pcp_pkg::PCP_LOAD |-> !global_set_reset_n && !done;
    endproperty
    a_gsr_held: assert property (p_gsr_held) else $error("global reset released during load");

    property p_abort;
        st_ff.state == pcp_pkg::PCP_LOAD && st_ff.pin_s2.reset_pin |=> st_ff.state == pcp_pkg::PCP_ABORT;
    endproperty
    a_abort: assert property (p_abort) else $error("reset pin did not abort");

    property p_startup;
        $rose(st_ff.state == pcp_pkg::PCP_STARTUP) |-> ##3 done && user_io_enable && global_set_reset_n;
    endproperty
    a_startup: assert property (p_startup) else $error("start-up did not finish in three cycles");

endmodule : pcp_top

/* File: pcp_host.sv */
// Purpose: host processor model writing bytes into the configuration port
// Assumes: pins change just after a clock edge; config_clock is made here
// Notes:   config_clock runs only inside a synchronous load
`timescale 1ns/1ps
module pcp_host (
    input  wire logic       clock,
    input  wire logic       ready,
    input  wire logic       status_bit_pin_out,
    input  wire logic       status_bit_pin_oe,
    output logic            config_clock,
    output logic            init_pin,
    output logic            chip_select_low_true_n,
    output logic            chip_select_high_true,
    output logic            wr_n,
    output logic            rd_n,
    output logic [7:0]      data_in
);
    int bad = 0;
    int cmp = 0;
    initial begin
        {config_clock, init_pin, chip_select_high_true} = 3'h0;
        {chip_select_low_true_n, wr_n, rd_n} = 3'h7;
        data_in = 8'h5a;
    end
    // ------------------------------------------------------------------------
    // bus cycles
    // ------------------------------------------------------------------------
    task automatic set_init(input logic v);
        @(posedge clock);
        init_pin <= v;
        repeat (6) @(posedge clock);
    endtask : set_init
    // sel_hold keeps both chip selects active after the status read
    task automatic async_byte(input logic [7:0] b, input logic sel_hold, output bit ok);
        ok = 1'b0;
        for (int i = 0; i < 300 && !ok; i++) begin
            @(negedge clock);
            ok = (ready === 1'b1);
        end
        @(posedge clock);
        {chip_select_low_true_n, chip_select_high_true} <= 2'h1;
        data_in <= b;
        wr_n <= 1'b0;
        repeat (4) @(posedge clock);
        wr_n <= 1'b1;
        repeat (4) @(posedge clock);
        rd_n <= 1'b0;
        data_in <= ~b;
        repeat (2) @(posedge clock);
        @(negedge clock);
        cmp++;
        if (status_bit_pin_oe !== 1'b1 || status_bit_pin_out !== ready) bad++;
        @(posedge clock);
        rd_n <= 1'b1;
        {chip_select_low_true_n, chip_select_high_true} <= {!sel_hold, sel_hold};
    endtask : async_byte
    // init low for four clocks with the clock running, then b[1] after the first ack and ~b[1] after the second
    task automatic sync_load(input logic [7:0] b [2]);
        int   k;
        logic prev;
        k = 0;
        prev = 1'b0;
        data_in = b[0];
        #3;
        for (int e = 0; e < 40; e++) begin
            init_pin = (e >= 4);
            #32 config_clock = 1'b1;
            #32 config_clock = 1'b0;
            if (prev === 1'b1) begin
                cmp++;
                if (ready !== 1'b0) bad++;
            end
            if (ready === 1'b1 && prev !== 1'b1 && k < 2) begin
                k++;
                data_in = (k < 2) ? b[k] : ~b[1];
            end
            prev = ready;
        end
        cmp++;
        if (k != 2) bad++;
    endtask : sync_load
endmodule : pcp_host

/* File: pcp_top_bench.sv */
// Purpose: self-checking bench of the configuration port
// Assumes: pcp_host drives the host pins
// Notes:   two bytes a load, every start-up order once, then an abort
`timescale 1ns/1ps
module pcp_top_bench;
    logic       clock, sys_rst, reset_pin, sync_mode, ready, dout, cfg_bit, cfg_bit_valid;
    logic       config_clock, init_pin, chip_select_low_true_n, chip_select_high_true, wr_n, rd_n;
    logic       global_set_reset_n, user_io_enable, done, status_bit_pin_out, status_bit_pin_oe;
    logic [1:0] startup_order;
    logic [7:0] data_in, bytes [2];
    logic [3:0] ord_tab [4] = '{4'he, 4'h0, 4'h6, 4'h1};
    bit         exp_q [$];
    bit         ok;
    int         failures = 0, comparisons = 0, seed = 393, cyc = 0, tg, ti, td;
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    pcp_top #(.CFG_BYTES(2)) uut (
        .clock, .sys_rst, .config_clock, .chip_select_low_true_n, .chip_select_high_true, .wr_n, .rd_n,
        .reset_pin, .init_pin, .sync_mode, .data_in, .startup_order, .status_bit_pin_out, .status_bit_pin_oe,
        .ready, .dout, .cfg_bit, .cfg_bit_valid, .global_set_reset_n, .user_io_enable, .done
    );
    pcp_host host (
        .clock, .ready, .status_bit_pin_out, .status_bit_pin_oe, .config_clock, .init_pin,
        .chip_select_low_true_n, .chip_select_high_true, .wr_n, .rd_n, .data_in
    );
    // ------------------------------------------------------------------------
    // checking
    // ------------------------------------------------------------------------
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    task automatic finish_test;
        failures += host.bad;
        comparisons += host.cmp;
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test
    always @(negedge clock) begin
        cyc++;
        if (global_set_reset_n === 1'b1 && tg < 0) tg = cyc;
        if (user_io_enable === 1'b1 && ti < 0) ti = cyc;
        if (done === 1'b1 && td < 0) td = cyc;
        if (!sys_rst && cfg_bit_valid === 1'b1) begin
            check({7'h0, cfg_bit}, exp_q.size() > 0 ? {7'h0, exp_q[0]} : 8'hee);
            if (!sync_mode) check({7'h0, dout}, exp_q.size() > 0 ? {7'h0, exp_q[0]} : 8'hee);
            if (exp_q.size() > 0) void'(exp_q.pop_front());
        end
    end
    // ------------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------------
    initial begin
        {sys_rst, reset_pin, sync_mode, startup_order} = 5'h10;
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        for (int l = 0; l < 5; l++) begin
            host.set_init(1'b0);
            sync_mode <= (l < 4) ? l[0] : 1'b0;
            startup_order <= l[1:0];
            tg = -1;
            ti = -1;
            td = -1;
            foreach (bytes[n]) begin
                bytes[n] = 8'($random(seed));
                for (int i = 7; i >= 0; i--) exp_q.push_back(bytes[n][i]);
            end
            if (l == 1 || l == 3) host.sync_load(bytes);
            else begin
                host.set_init(1'b1);
                check({7'h0, global_set_reset_n}, 8'h0);
                foreach (bytes[n]) begin
                    if (l == 4 && n == 1) begin
                        repeat (20) @(posedge clock);
                        exp_q.delete();
                        reset_pin <= 1'b1;
                    end
                    host.async_byte(bytes[n], n[0], ok);
                    if (!ok) begin
                        failures++;
                        finish_test();
                    end
                end
            end
            for (int w = 0; w < 400 && l < 4 && done !== 1'b1; w++) @(posedge clock);
            if (l < 4) check({7'h0, done}, 8'h1);
            repeat (10) @(posedge clock);
            if (l < 4) check({4'h0, tg < ti, ti < td, tg < td, tg == td}, {4'h0, ord_tab[l]});
        end
        repeat (100) @(posedge clock);
        check({6'h0, done, global_set_reset_n}, 8'h0);
        finish_test();
    end
endmodule : pcp_top_bench
